// ---- shared/gain_ctrl_pkg.sv ----
/*
 package for the input gain control register bank: register indices, field
 positions, reset values.
 assumes a register port with a 7-bit index and 16-bit data words.
*/
`default_nettype none
package gain_ctrl_pkg;
  localparam logic [6:0]  ADDR_LEFT_PAIR12_GAIN   = 7'h18;
  localparam logic [6:0]  ADDR_LEFT_PAIR34_GAIN   = 7'h19;
  localparam logic [6:0]  ADDR_RIGHT_PAIR12_GAIN  = 7'h1a;
  localparam logic [6:0]  ADDR_RIGHT_PAIR34_GAIN  = 7'h1b;
  localparam logic [6:0]  ADDR_AMP_INPUT_SELECT   = 7'h28;
  localparam logic [6:0]  ADDR_ANTI_POP_CONTROL   = 7'h39;
  localparam int          NUM_AMPS                = 4;
  localparam int          GAIN_W                  = 5;
  localparam int          BIT_UPDATE              = 8;
  localparam int          BIT_MUTE                = 7;
  localparam int          BIT_ZC                  = 6;
  localparam int          BIT_MIDREF              = 3;
  localparam logic [4:0]  GAIN_RESET              = 5'h0b;
  localparam logic        MUTE_RESET              = 1'h1;
  localparam logic        ZC_RESET                = 1'h0;
  localparam logic [7:0]  SELECT_RESET            = 8'h00;
  localparam logic        MIDREF_RESET            = 1'h0;
  typedef enum logic [1:0] {APPLY_IDLE, APPLY_WAIT} apply_state_t;
endpackage : gain_ctrl_pkg
`default_nettype wire

// ---- src/input_gain_control_regs.sv ----
/*
 input gain control register bank: pin connection bits, buffered mid-reference
 enable, per-amplifier staged/applied gain with mute and zero-cross gating.
 assumes the serial control port decoder delivers one-cycle write strobes and
 combinational-free read indices on i_clk_sys; zero-cross and timeout inputs
 come from other clock domains and are synchronised here.
*/
`default_nettype none
module input_gain_control_regs
  import gain_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_arst_n,
  // register port
  input  wire logic                     i_reg_wr,
  input  wire logic [6:0]               i_reg_addr,
  input  wire logic [15:0]              i_reg_wdata,
  output logic      [15:0]              o_reg_rdata,
  // clocking block and analogue events
  input  wire logic                     i_timeout_enable,
  input  wire logic                     i_timeout_tick,
  input  wire logic [NUM_AMPS-1:0]      i_zero_cross,
  // analogue controls
  output logic      [7:0]               o_input_select,
  output logic                          o_buffered_midref_enable,
  output logic      [NUM_AMPS*GAIN_W-1:0] o_applied_gain,
  output logic      [NUM_AMPS-1:0]      o_mute,
  output logic      [NUM_AMPS-1:0]      o_gain_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic [2:0] vol_index(input logic [6:0] addr);
    // 3'h4 means not a volume register
    case (addr)
      ADDR_LEFT_PAIR12_GAIN:  vol_index = 3'h0;
      ADDR_LEFT_PAIR34_GAIN:  vol_index = 3'h1;
      ADDR_RIGHT_PAIR12_GAIN: vol_index = 3'h2;
      ADDR_RIGHT_PAIR34_GAIN: vol_index = 3'h3;
      default:                vol_index = 3'h4;
    endcase
  endfunction : vol_index

  logic [2:0] wr_idx;
  logic       wr_vol;
  logic       update_all;
  assign wr_idx     = vol_index(i_reg_addr);
  assign wr_vol     = i_reg_wr && !wr_idx[2];
  assign update_all = wr_vol && i_reg_wdata[BIT_UPDATE];

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers; first stage read only by the second
  logic [NUM_AMPS:0] sync1_q;
  logic [NUM_AMPS:0] sync2_q;
  logic [NUM_AMPS:0] sync3_q;
  logic [NUM_AMPS:0] sync_d;
  logic [NUM_AMPS:0] edge_evt;
  assign sync_d   = {i_timeout_tick, i_zero_cross};
  assign edge_evt = sync2_q & ~sync3_q;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= sync_d;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic ena1_q;
  logic ena2_q;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ena1_q <= 1'h0;
      ena2_q <= 1'h0;
    end else begin
      ena1_q <= i_timeout_enable;
      ena2_q <= ena1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared registers
  logic [7:0] select_q;
  logic [7:0] select_d;
  logic       midref_q;
  logic       midref_d;

  always_comb begin
    select_d = select_q;
    midref_d = midref_q;
    if (i_reg_wr && i_reg_addr == ADDR_AMP_INPUT_SELECT) begin
      select_d = i_reg_wdata[7:0];
    end
    if (i_reg_wr && i_reg_addr == ADDR_ANTI_POP_CONTROL) begin
      midref_d = i_reg_wdata[BIT_MIDREF];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      select_q <= SELECT_RESET;
      midref_q <= MIDREF_RESET;
    end else begin
      select_q <= select_d;
      midref_q <= midref_d;
    end
  end

  assign o_input_select           = select_q;
  assign o_buffered_midref_enable = midref_q;

  ////////////////////////////////////////////////////////////////////////////
  // per-amplifier staged and applied gain
  logic [GAIN_W-1:0] stored_q  [NUM_AMPS];
  logic [GAIN_W-1:0] applied_q [NUM_AMPS];
  // unpacked so each amp's process drives only its own element
  logic                mute_q    [NUM_AMPS];
  logic                zc_q      [NUM_AMPS];
  logic [NUM_AMPS-1:0] pend_q;
  logic [NUM_AMPS-1:0] mute_vec;

  genvar g;
  generate
    for (g = 0; g < NUM_AMPS; g++) begin : g_amp
      logic [GAIN_W-1:0] stored_d;
      logic [GAIN_W-1:0] applied_d;
      logic              mute_d;
      logic              zc_d;
      apply_state_t      st_q;
      apply_state_t      st_d;
      logic              hit;

      always_comb begin
        stored_d  = stored_q[g];
        applied_d = applied_q[g];
        mute_d    = mute_q[g];
        zc_d      = zc_q[g];
        st_d      = st_q;
        hit       = 1'h0;
        if (wr_vol && wr_idx[1:0] == 2'(g)) begin
          stored_d = i_reg_wdata[GAIN_W-1:0];
          mute_d   = i_reg_wdata[BIT_MUTE];
          zc_d     = i_reg_wdata[BIT_ZC];
        end
        case (st_q)
          APPLY_IDLE: begin
            if (update_all) begin
              if (zc_d) begin
                st_d = APPLY_WAIT;
              end else begin
                applied_d = stored_d;
              end
            end
          end
          APPLY_WAIT: begin
            // the code taken is the latest stored one, so late writes win
            hit = edge_evt[g] || (ena2_q && edge_evt[NUM_AMPS]);
            if (hit || !zc_q[g]) begin
              applied_d = stored_q[g];
              st_d      = APPLY_IDLE;
            end
          end
          default: st_d = APPLY_IDLE;
        endcase
      end

      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
          stored_q[g]  <= GAIN_RESET;
          applied_q[g] <= GAIN_RESET;
          mute_q[g]    <= MUTE_RESET;
          zc_q[g]      <= ZC_RESET;
          st_q         <= APPLY_IDLE;
        end else begin
          stored_q[g]  <= stored_d;
          applied_q[g] <= applied_d;
          mute_q[g]    <= mute_d;
          zc_q[g]      <= zc_d;
          st_q         <= st_d;
        end
      end

      assign pend_q[g]   = (st_q == APPLY_WAIT);
      assign mute_vec[g] = mute_q[g];
      // one code per amp feeds both inputs, so they cannot differ
      assign o_applied_gain[g*GAIN_W +: GAIN_W] = applied_q[g];
    end
  endgenerate

  assign o_mute         = mute_vec;
  assign o_gain_pending = pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // readback: update bit reads zero, unmapped reads zero
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic [2:0]  rd_idx;
  assign rd_idx = vol_index(i_reg_addr);

  always_comb begin
    rdata_d = 16'h0000;
    if (!rd_idx[2]) begin
      rdata_d[BIT_MUTE]     = mute_q[rd_idx[1:0]];
      rdata_d[BIT_ZC]       = zc_q[rd_idx[1:0]];
      rdata_d[GAIN_W-1:0]   = stored_q[rd_idx[1:0]];
    end else if (i_reg_addr == ADDR_AMP_INPUT_SELECT) begin
      rdata_d[7:0] = select_q;
    end else if (i_reg_addr == ADDR_ANTI_POP_CONTROL) begin
      rdata_d[BIT_MIDREF] = midref_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_reg_rdata = rdata_q;

endmodule : input_gain_control_regs
`default_nettype wire

// ---- verif/gain_ctrl_monitor.sv ----
/* checker for the input gain bank, seeing only its top ports.
 assumes one clock domain and a bind to the bank. */
`default_nettype none
module gain_ctrl_monitor
  import gain_ctrl_pkg::*;
(
  // inputs
  input wire logic i_clk_sys, i_arst_n, i_reg_wr, i_timeout_enable, i_timeout_tick,
  input wire logic [6:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [3:0] i_zero_cross,
  // outputs
  input wire logic [7:0] o_input_select,
  input wire logic o_buffered_midref_enable,
  input wire logic [19:0] o_applied_gain,
  input wire logic [3:0] o_mute, o_gain_pending
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] wd_q;
  logic vol_w, a0_w;
  assign vol_w = i_reg_wr && i_reg_addr[6:2] == 5'h06;
  assign a0_w = i_reg_wr && i_reg_addr == ADDR_LEFT_PAIR12_GAIN;
  // last word, so no $past on slices
  always_ff @(posedge i_clk_sys) wd_q <= i_reg_wdata;
  reset_val_a: assert property ($rose(i_arst_n) |-> o_mute == 4'hf
    && o_applied_gain == {4{GAIN_RESET}}) else $error("reset value");
  midref_a: assert property (i_reg_wr && i_reg_addr == ADDR_ANTI_POP_CONTROL
    |=> o_buffered_midref_enable == wd_q[BIT_MIDREF]) else $error("midref");
  select_a: assert property (i_reg_wr && i_reg_addr == ADDR_AMP_INPUT_SELECT
    |=> o_input_select == wd_q[7:0]) else $error("select");
  mute_a: assert property (a0_w |=> o_mute[0] == wd_q[BIT_MUTE]) else $error("mute");
  store_only_a: assert property (vol_w && !i_reg_wdata[BIT_UPDATE]
    && o_gain_pending == 4'h0 |=> $stable(o_applied_gain)) else $error("store");
  apply_now_a: assert property (a0_w && i_reg_wdata[BIT_UPDATE]
    && !i_reg_wdata[BIT_ZC] && !o_gain_pending[0] |=> o_applied_gain[4:0] == wd_q[4:0])
    else $error("apply");
  gate_a: assert property (a0_w && i_reg_wdata[BIT_UPDATE] && i_reg_wdata[BIT_ZC]
    && !o_gain_pending[0] |=> o_gain_pending[0] && $stable(o_applied_gain[4:0]))
    else $error("gate");
  zc_apply_a: assert property (o_gain_pending[0] && $rose(i_zero_cross[0])
    |-> ##[1:5] !o_gain_pending[0]) else $error("zero cross");
  timeout_a: assert property (o_gain_pending != 4'h0 && i_timeout_enable
    && $rose(i_timeout_tick) |-> ##[1:5] o_gain_pending == 4'h0) else $error("timeout");
  cover property (vol_w && i_reg_wdata[BIT_UPDATE]);
  cover property ($fell(o_gain_pending[0]));
  cover property ($fell(o_gain_pending[1]));
endmodule : gain_ctrl_monitor
bind input_gain_control_regs gain_ctrl_monitor gain_ctrl_monitor_inst (.i_clk_sys, .i_arst_n,
  .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_timeout_enable, .i_timeout_tick, .i_zero_cross,
  .o_input_select, .o_buffered_midref_enable, .o_applied_gain, .o_mute, .o_gain_pending);
`default_nettype wire

// ---- verif/host_model.sv ----
/* host processor model: writes and reads bank registers.
 assumes writes are taken on the rising edge, read data one cycle late. */
`default_nettype none
module host_model (
  // register port
  input wire logic i_clk_sys,
  output var logic o_reg_wr,
  output var logic [6:0] o_reg_addr,
  output var logic [15:0] o_reg_wdata,
  input wire logic [15:0] i_reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_reg_wr = 1'b0;
    o_reg_addr = 7'h00;
    o_reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    o_reg_wr <= 1'b1;
    o_reg_addr <= a;
    o_reg_wdata <= d;
    @(posedge i_clk_sys);
    o_reg_wr <= 1'b0;
    o_reg_wdata <= ~d; // released data never repeats the word
    @(negedge i_clk_sys);
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    o_reg_addr <= a;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    d = i_reg_rdata;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ---- verif/input_gain_control_regs_test.sv ----
/* bench for the input gain bank, driving it through the host model.
 assumes package, host model and checker compiled first. */
`default_nettype none
module input_gain_control_regs_test
  import gain_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'b0, i_arst_n = 1'b0, i_timeout_enable = 1'b0, i_timeout_tick = 1'b0;
  logic [3:0] i_zero_cross = 4'h0, mx = 4'hf;
  wire logic i_reg_wr, o_buffered_midref_enable;
  wire logic [6:0] i_reg_addr;
  wire logic [15:0] i_reg_wdata, o_reg_rdata;
  wire logic [7:0] o_input_select;
  wire logic [19:0] o_applied_gain;
  wire logic [3:0] o_mute, o_gain_pending;
  logic [15:0] lf = 16'hfcbb, d, rv;
  logic [4:0] sg [4] = '{default: GAIN_RESET};
  logic [4:0] nx [4];
  logic [7:0] cfg [3] = '{8'h55, 8'hff, 8'h00};
  int n_fail = 0, n_compared = 0, cyc = 0;
  host_model host_model_inst (.i_clk_sys, .o_reg_wr(i_reg_wr), .o_reg_addr(i_reg_addr),
    .o_reg_wdata(i_reg_wdata), .i_reg_rdata(o_reg_rdata));
  input_gain_control_regs input_gain_control_regs_inst (.i_clk_sys, .i_arst_n, .i_reg_wr,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_timeout_enable, .i_timeout_tick,
    .i_zero_cross, .o_input_select, .o_buffered_midref_enable, .o_applied_gain, .o_mute,
    .o_gain_pending);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [19:0] exp_gain();
    return {sg[3], sg[2], sg[1], sg[0]};
  endfunction : exp_gain
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  // amp a staged with gating, released by zero cross (amp 0) or tick
  task automatic gated(input int a, input logic [4:0] g);
    host_model_inst.wr(ADDR_LEFT_PAIR12_GAIN + 7'(a), {7'h00, 4'b1010, g});
    chk({o_gain_pending[a], o_applied_gain}, {1'b1, exp_gain()});
    @(posedge i_clk_sys);
    if (a == 0) i_zero_cross <= 4'h1;
    else i_timeout_tick <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_zero_cross <= 4'h0;
    i_timeout_tick <= 1'b0;
    for (int t = 0; t < 8 && o_gain_pending != 4'h0; t++) @(negedge i_clk_sys);
    sg[a] = g;
    chk({o_gain_pending, o_applied_gain}, {4'h0, exp_gain()});
  endtask : gated
  initial forever #25 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    i_timeout_enable <= 1'b1;
    @(negedge i_clk_sys);
    chk({o_mute, o_input_select, o_buffered_midref_enable}, 24'h1e00);
    chk(o_applied_gain, exp_gain());
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      d = {8'h00, k < 3 ? cfg[k] : lf[7:0]};
      host_model_inst.wr(ADDR_AMP_INPUT_SELECT, d);
      chk(o_input_select, d[7:0]);
      host_model_inst.rd(ADDR_AMP_INPUT_SELECT, rv);
      chk(rv, d);
      host_model_inst.wr(ADDR_ANTI_POP_CONTROL, {12'h000, lf[15], 3'h0});
      chk(o_buffered_midref_enable, lf[15]);
    end
    host_model_inst.wr(ADDR_ANTI_POP_CONTROL, 16'h0008);
    host_model_inst.rd(7'h20, rv);
    chk(rv, 24'h0);
    $display("select test done");
    for (int a = 0; a < 4; a++) begin
      lf = lfsr(lf);
      nx[a] = a == 0 ? 5'h1f : a == 1 ? 5'h00 : lf[4:0];
      mx[a] = lf[7];
      host_model_inst.wr(ADDR_LEFT_PAIR12_GAIN + 7'(a), {8'h00, lf[7], 2'b00, nx[a]});
      chk({o_mute, o_applied_gain}, {mx, exp_gain()});
      host_model_inst.rd(ADDR_LEFT_PAIR12_GAIN + 7'(a), rv);
      chk(rv, {8'h00, mx[a], 2'b00, nx[a]});
    end
    host_model_inst.wr(ADDR_LEFT_PAIR12_GAIN, {7'h00, 1'b1, mx[0], 2'b00, nx[0]});
    sg = nx;
    chk(o_applied_gain, exp_gain());
    $display("update test done");
    lf = lfsr(lf);
    gated(0, lf[4:0]);
    gated(1, lf[9:5]);
    $display("gating test done");
    complete_run();
  end
endmodule : input_gain_control_regs_test
`default_nettype wire
